//--- mted_pkg.sv
/*
  Constants of the outside-of-thresholds event detector: register indices,
  field positions and reset values.
  Assumes an APB master with 32-bit data; byte address = index * 4.
*/
package mted_pkg;
  localparam int SAMPLE_W = 12;
  localparam int DBC_W    = 8;
  localparam int AXES     = 3;
  localparam int APB_AW   = 10;

  // Register indices
  localparam logic [7:0] IDX_STATUS   = 8'h2D;
  localparam logic [7:0] IDX_CONFIG   = 8'h30;
  localparam logic [7:0] IDX_UPPER    = 8'h31;
  localparam logic [7:0] IDX_LOWER    = 8'h32;
  localparam logic [7:0] IDX_DEBOUNCE = 8'h33;
  localparam logic [7:0] IDX_IRQ_ST   = 8'h34;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h35;

  // Status byte fields; axis i uses X bit minus 2*i
  localparam int ST_EA_BIT    = 7;
  localparam int ST_RSV_BIT   = 6;
  localparam int ST_X_EF_BIT  = 5;
  localparam int ST_X_POL_BIT = 4;

  // Configuration fields
  localparam int CFG_X_EN_BIT   = 0;
  localparam int CFG_REL_BIT    = 3;
  localparam int CFG_LATCH_BIT  = 4;
  localparam int CFG_WAKE_BIT   = 5;
  localparam int CFG_ROUTE_BIT  = 6;
  localparam int CFG_PINSEL_BIT = 7;

  // Interrupt status fields
  localparam int IRQ_W        = 2;
  localparam int IRQ_RISE_BIT = 0;
  localparam int IRQ_FALL_BIT = 1;

  // Reset values
  localparam logic [7:0]        CONFIG_RST   = 8'h00;
  localparam logic [15:0]       UPPER_RST    = 16'h0000;
  localparam logic [15:0]       LOWER_RST    = 16'h0000;
  localparam logic [DBC_W-1:0]  DEBOUNCE_RST = 8'h00;
  localparam logic [7:0]        STATUS_RST   = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RST      = 2'h0;
endpackage

//--- mted_detector.sv
/*
  Outside-of-thresholds event detector for a three-axis sensor, with its
  status, configuration and interrupt registers on an APB slave.
  Assumes one clock; sampleValid pulses once per output data rate period
  with fresh signed samples on xSample, ySample and zSample.
*/
// The APB register port is this design's own decision.
// Behaviour
// - Active flag only after debounce count periods
// - Unlatched active flag 0 while all axes inside
// - Axis flag set on or beyond threshold
// - Disabled axes never flag nor contribute
// - Polarity 1 upper, 0 lower
// - Absolute samples or sample deltas compared
// - No axis enabled means function inactive
// - Wake option restarts sleep timer while active
// - Active flag routable to either interrupt pin
// - Read-only status byte, bit 6 zero
// - Polarity captured when axis flag sets
// - Unlatched flags update once debounce reached
// - Z flag bit 1, Z polarity bit 0
`timescale 1ns/10ps
module mted_detector
  import mted_pkg::*;
#(
  parameter int DATA_W = SAMPLE_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Samples
  input  wire logic              sampleValid,
  input  wire logic [DATA_W-1:0] xSample,
  input  wire logic [DATA_W-1:0] ySample,
  input  wire logic [DATA_W-1:0] zSample,
  // Events
  output logic                   interrupt_pin_one,
  output logic                   interrupt_pin_two,
  output logic                   irq,
  output logic                   sleepTimerRestart,
  output logic                   sleepHold
);
  if (DATA_W < 2 || DATA_W > 16) begin : g_bad_width
    $error("DATA_W must be 2 to 16");
  end

  localparam int CMP_W = DATA_W + 1;

  logic [7:0]        configR, configNxt;
  logic [DATA_W-1:0] upperR, upperNxt, lowerR, lowerNxt;
  logic [DBC_W-1:0]  dbcR, dbcNxt, cntR, cntNxt;
  logic              eaR, eaNxt;
  logic [AXES-1:0]   efR, efNxt, polR, polNxt;
  logic [IRQ_W-1:0]  irqStR, irqStNxt, irqMaskR, irqMaskNxt;
  logic [DATA_W-1:0] prevR [AXES], prevNxt [AXES];

  logic [DATA_W-1:0] sampleVal [AXES];
  logic signed [CMP_W-1:0] cmpVal [AXES];
  logic signed [CMP_W-1:0] upperExt, lowerExt;
  logic [AXES-1:0]   outside, atUpper, axisEn;
  logic              anyOut, reached, latchMode, relMode;
  logic [DBC_W:0]    cntInc;
  logic [7:0]        regIdx, statusByte;
  logic              acc, rdAcc, wrAcc, mapped;
  logic              statusRd, irqRd;

  assign sampleVal[0] = xSample;
  assign sampleVal[1] = ySample;
  assign sampleVal[2] = zSample;

  assign axisEn    = configR[CFG_X_EN_BIT +: AXES];
  assign relMode   = configR[CFG_REL_BIT];
  assign latchMode = configR[CFG_LATCH_BIT];
  assign upperExt  = CMP_W'(signed'(upperR));
  assign lowerExt  = CMP_W'(signed'(lowerR));

  // Per-axis comparison
  for (genvar i = 0; i < AXES; i++) begin : g_axis
    logic signed [CMP_W-1:0] cur, prv;
    assign cur = CMP_W'(signed'(sampleVal[i]));
    assign prv = CMP_W'(signed'(prevR[i]));
    // Delta of two DATA_W values fits CMP_W exactly
    assign cmpVal[i] = relMode ? cur - prv : cur;
    assign atUpper[i] = cmpVal[i] >= upperExt;
    assign outside[i] = axisEn[i] &&
                        (atUpper[i] || cmpVal[i] <= lowerExt);
    // Status byte: X at 5/4, Y at 3/2, Z at 1/0
    assign statusByte[ST_X_EF_BIT - 2*i]  = efR[i];
    assign statusByte[ST_X_POL_BIT - 2*i] = polR[i];
  end

  assign statusByte[ST_EA_BIT]  = eaR;
  assign statusByte[ST_RSV_BIT] = 1'b0;

  assign anyOut  = |outside;
  assign cntInc  = {1'b0, cntR} + 1'b1;
  // Count includes the current period, so a count of 0 or 1 acts at once
  assign reached = anyOut && (cntInc >= {1'b0, dbcR});

  // APB decode
  assign regIdx  = paddr[APB_AW-1:2];
  assign acc     = psel && penable;
  assign rdAcc   = acc && !pwrite;
  assign wrAcc   = acc && pwrite;
  assign mapped  = (paddr[1:0] == 2'h0) &&
                   (regIdx == IDX_STATUS || regIdx == IDX_CONFIG ||
                    regIdx == IDX_UPPER || regIdx == IDX_LOWER ||
                    regIdx == IDX_DEBOUNCE || regIdx == IDX_IRQ_ST ||
                    regIdx == IDX_IRQ_MASK);
  assign statusRd = rdAcc && mapped && regIdx == IDX_STATUS;
  assign irqRd    = rdAcc && mapped && regIdx == IDX_IRQ_ST;
  assign pready   = 1'b1;
  assign pslverr  = acc && !mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    if (mapped) begin
      unique case (regIdx)
        IDX_STATUS:   prdata[7:0] = statusByte;
        IDX_CONFIG:   prdata[7:0] = configR;
        IDX_UPPER:    prdata[DATA_W-1:0] = upperR;
        IDX_LOWER:    prdata[DATA_W-1:0] = lowerR;
        IDX_DEBOUNCE: prdata[DBC_W-1:0] = dbcR;
        IDX_IRQ_ST:   prdata[IRQ_W-1:0] = irqStR;
        IDX_IRQ_MASK: prdata[IRQ_W-1:0] = irqMaskR;
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  // Next state: registers, detector, interrupt status
  always_comb begin
    logic [AXES-1:0] efBase;
    logic            eaBase;
    efBase     = (statusRd && latchMode) ? '0 : efR;
    eaBase     = (statusRd && latchMode) ? 1'b0 : eaR;
    configNxt  = configR;
    upperNxt   = upperR;
    lowerNxt   = lowerR;
    dbcNxt     = dbcR;
    irqMaskNxt = irqMaskR;
    if (wrAcc && mapped) begin
      unique case (regIdx)
        IDX_CONFIG:   configNxt = pwdata[7:0];
        IDX_UPPER:    upperNxt = pwdata[DATA_W-1:0];
        IDX_LOWER:    lowerNxt = pwdata[DATA_W-1:0];
        IDX_DEBOUNCE: dbcNxt = pwdata[DBC_W-1:0];
        IDX_IRQ_MASK: irqMaskNxt = pwdata[IRQ_W-1:0];
        default:      configNxt = configR;
      endcase
    end
    cntNxt  = cntR;
    efNxt   = efBase;
    polNxt  = polR;
    eaNxt   = eaBase;
    prevNxt = prevR;
    if (sampleValid) begin
      prevNxt = sampleVal;
      if (!anyOut) begin
        cntNxt = '0;
      end else if (!cntInc[DBC_W]) begin
        cntNxt = cntInc[DBC_W-1:0];
      end
      for (int i = 0; i < AXES; i++) begin
        // Latched: only a freshly set flag captures polarity
        if (reached && outside[i] && !(latchMode && efBase[i])) begin
          polNxt[i] = atUpper[i];
        end
      end
      if (latchMode) begin
        efNxt = efBase | (reached ? outside : '0);
        eaNxt = eaBase | reached;
      end else begin
        efNxt = reached ? outside : '0;
        eaNxt = reached;
      end
    end
    // A new event wins over a clearing read
    irqStNxt = irqRd ? IRQ_RST : irqStR;
    irqStNxt[IRQ_RISE_BIT] = irqStNxt[IRQ_RISE_BIT] | (eaNxt && !eaR);
    irqStNxt[IRQ_FALL_BIT] = irqStNxt[IRQ_FALL_BIT] | (!eaNxt && eaR);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      configR  <= CONFIG_RST;
      upperR   <= UPPER_RST[DATA_W-1:0];
      lowerR   <= LOWER_RST[DATA_W-1:0];
      dbcR     <= DEBOUNCE_RST;
      irqMaskR <= IRQ_RST;
      irqStR   <= IRQ_RST;
      cntR     <= '0;
      eaR      <= STATUS_RST[ST_EA_BIT];
      efR      <= '0;
      polR     <= '0;
      for (int i = 0; i < AXES; i++) begin
        prevR[i] <= '0;
      end
    end else begin
      configR  <= configNxt;
      upperR   <= upperNxt;
      lowerR   <= lowerNxt;
      dbcR     <= dbcNxt;
      irqMaskR <= irqMaskNxt;
      irqStR   <= irqStNxt;
      cntR     <= cntNxt;
      eaR      <= eaNxt;
      efR      <= efNxt;
      polR     <= polNxt;
      prevR    <= prevNxt;
    end
  end

  // Event outputs
  assign interrupt_pin_one = configR[CFG_ROUTE_BIT] &&
                             !configR[CFG_PINSEL_BIT] && eaR;
  assign interrupt_pin_two = configR[CFG_ROUTE_BIT] &&
                             configR[CFG_PINSEL_BIT] && eaR;
  assign irq = |(irqStR & irqMaskR);
  // Sleep stays held off for as long as the flag stands
  assign sleepHold = configR[CFG_WAKE_BIT] && eaR;
  assign sleepTimerRestart = sleepHold && sampleValid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_debounce_gate: assert property (
    sampleValid && !latchMode && anyOut && cntInc < {1'b0, dbcR}
    |=> !eaR)
    else $error("active flag set before debounce count");
  a_inside_clear: assert property (
    sampleValid && !latchMode && !anyOut |=> !eaR && efR == '0)
    else $error("active flag set while all axes inside");
  a_upper_hit: assert property (
    sampleValid && !latchMode && dbcR == '0 && axisEn[0] &&
    cmpVal[0] >= upperExt |=> efR[0] && eaR)
    else $error("x flag missing at upper threshold");
  a_disabled_axis: assert property (
    sampleValid && !latchMode && !axisEn[1] |=> !efR[1])
    else $error("disabled y axis flagged");
  a_polarity_low: assert property (
    sampleValid && !latchMode && reached && outside[2] && !atUpper[2]
    |=> !polR[2] && statusByte[0] == 1'b0)
    else $error("z polarity wrong at lower threshold");
  a_relative_still: assert property (
    sampleValid && relMode && !latchMode && xSample == prevR[0] &&
    upperExt > 0 && lowerExt < 0 |=> !efR[0])
    else $error("unchanged x flagged in relative mode");
  a_none_enabled: assert property (
    sampleValid && !latchMode && axisEn == '0 |=> !eaR)
    else $error("flag set with no axis enabled");
  a_sleep_hold: assert property (
    configR[CFG_WAKE_BIT] && eaR && sampleValid |-> sleepTimerRestart)
    else $error("sleep timer not restarted while active");
  a_pin_route: assert property (
    eaR && configR[CFG_ROUTE_BIT] |->
    (interrupt_pin_one != interrupt_pin_two))
    else $error("active flag not routed to one pin");
  a_status_read: assert property (
    statusRd |-> prdata[7] == eaR && prdata[6] == 1'b0 &&
    prdata[31:8] == '0)
    else $error("status byte read wrong");
  a_latch_pol: assert property (
    latchMode && efR[0] && !statusRd |=> polR[0] == $past(polR[0]))
    else $error("latched x polarity changed");
  a_count_restart: assert property (
    sampleValid && !anyOut |=> cntR == '0)
    else $error("debounce count not restarted");
  a_hold_between: assert property (
    !sampleValid && !statusRd |=> $stable(efR) && $stable(eaR))
    else $error("flags changed without a sample");

  c_event_rise: cover property (sampleValid ##1 $rose(eaR));
  c_debounced:  cover property (dbcR > 8'h02 ##0 $rose(eaR));
  c_latch_read: cover property (latchMode && eaR && statusRd ##1 !eaR);
  c_relative:   cover property (relMode && reached);
  c_irq:        cover property ($rose(irq));
endmodule

//--- mted_host.sv
/*
  Host model: APB master for all register access of the bench.
  Assumes a slave on the same clock; wait states are honoured.
*/
`timescale 1ns/10ps
module mted_host
  import mted_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // APB master
  output logic                   psel    = 1'h0,
  output logic                   penable = 1'h0,
  output logic                   pwrite  = 1'h0,
  output logic      [APB_AW-1:0] paddr   = '0,
  output logic      [31:0]       pwdata  = '0,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  // Request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

//--- testbench.sv
/*
  Self-checking bench of the outside-of-thresholds event detector.
  Assumes mted_host for APB access; samples are driven from here.
*/
`timescale 1ns/10ps
module testbench
  import mted_pkg::*;
;
  logic               clk = 1'h0, rst_n, sampleValid, irq, pinOne, pinTwo;
  logic               psel, penable, pwrite, pready, pslverr, errS, expA;
  logic               restart, hold;
  logic [APB_AW-1:0]  paddr;
  logic [31:0]        pwdata, prdata, q;
  logic [7:0]         cfg, e;
  logic [2:0]         polM, fM;
  logic signed [11:0] xs, ys, zs, up, lo;
  logic signed [12:0] prev [3];
  logic [11:0]        dbS [7] = '{12'h0C8, 12'h0C8, 12'h0, 12'h0C8,
                                  12'h0C8, 12'h0C8, 12'h0};
  logic [7:0]         dbE [7] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'hB0, 8'h10};
  integer             seed = 32'h59A7DEEA;
  int                 fails, n_checks;

  mted_detector i_mted_detector (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleValid(sampleValid), .xSample(xs), .ySample(ys), .zSample(zs),
    .interrupt_pin_one(pinOne), .interrupt_pin_two(pinTwo), .irq(irq),
    .sleepTimerRestart(restart), .sleepHold(hold));
  mted_host i_mted_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  always #10 clk = ~clk;

  task automatic chkW(input string n, input logic [31:0] x, g);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chkB(input string n, input logic x, g);
    chkW(n, {31'h0, x}, {31'h0, g});
  endtask
  function automatic logic [11:0] rnd();
    return 12'($random(seed));
  endfunction
  task automatic rd(input logic [7:0] idx);
    i_mted_host.xfer(1'h0, idx, 32'h0, q, errS);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    i_mted_host.xfer(1'h1, idx, d, q, errS);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Mid-run reset, so every test starts from cleared flags
  task automatic setup(input logic [7:0] c, input logic [11:0] u, l, dbc);
    rst_n <= 1'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    {polM, fM, expA, cfg, up, lo} = {7'h0, c, u, l};
    prev = '{default: 13'sh0};
    wr(IDX_CONFIG, {24'h0, c});
    wr(IDX_UPPER, {20'h0, u});
    wr(IDX_LOWER, {20'h0, l});
    wr(IDX_DEBOUNCE, {20'h0, dbc});
  endtask
  // Inverted samples between pulses must be ignored
  task automatic smp(input logic [11:0] x, y, z);
    @(posedge clk);
    {sampleValid, xs, ys, zs} <= {1'h1, x, y, z};
    #1 chkB("restart", cfg[CFG_WAKE_BIT] & expA, restart);
    @(posedge clk);
    {sampleValid, xs, ys, zs} <= {1'h0, ~x, ~y, ~z};
  endtask
  function automatic logic [7:0] expSt(input logic signed [12:0] v [3]);
    logic [7:0] r;
    logic hit;
    r = 8'h0;
    for (int a = 0; a < 3; a++) begin
      hit = cfg[CFG_X_EN_BIT + a] && (v[a] >= up || v[a] <= lo);
      // Unlatched: recaptured on every hit; latched: only when fresh
      if (hit && !(cfg[CFG_LATCH_BIT] && fM[a])) polM[a] = v[a] >= up;
      fM[a] = hit;
      r[ST_X_EF_BIT - 2 * a] = hit;
      r[ST_X_POL_BIT - 2 * a] = polM[a];
    end
    r[ST_EA_BIT] = |fM;
    expA = r[ST_EA_BIT];
    return r;
  endfunction
  task automatic step(input logic signed [11:0] x, y, z);
    logic signed [12:0] v [3];
    smp(x, y, z);
    v = '{x, y, z};
    for (int a = 0; a < 3; a++) v[a] -= cfg[CFG_REL_BIT] ? prev[a] : 13'sh0;
    prev = '{x, y, z};
    e = expSt(v);
    rd(IDX_STATUS);
    chkW("status", {24'h0, e}, q);
    chkB("pin one", e[7] & cfg[6] & ~cfg[7], pinOne);
    chkB("pin two", e[7] & cfg[6] & cfg[7], pinTwo);
    chkB("sleep hold", e[7] & cfg[5], hold);
  endtask

  initial begin
    {rst_n, sampleValid, xs, ys, zs, cfg, expA} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    rd(IDX_STATUS);
    chkW("status reset", 32'h0, q);
    chkB("pready", 1'h1, pready);
    wr(IDX_STATUS, 32'hFF);
    rd(IDX_STATUS);
    chkW("status read only", 32'h0, q);
    rd(8'hFF);
    chkB("unmapped error", 1'h1, errS);
    $display("test registers finished");
    setup(8'h67, rnd() & 12'h7FF, rnd() | 12'h800, 12'h1);
    step(up, rnd(), lo);
    step(lo, rnd(), up);
    step(up - 12'h1, up, lo + 12'h1);
    for (int i = 0; i < 36; i++) begin
      if (i % 6 == 0) begin
        cfg = 8'(rnd()) & (i == 30 ? 8'hE0 : 8'hE7);
        wr(IDX_CONFIG, {24'h0, cfg});
      end
      step(rnd(), rnd(), rnd());
    end
    $display("test random absolute finished");
    setup(8'h61, 12'h064, 12'hF9C, 12'h3);
    for (int i = 0; i < 7; i++) begin
      smp(dbS[i], 12'h0, 12'h0);
      expA = dbE[i][ST_EA_BIT];
      rd(IDX_STATUS);
      chkW("debounced status", {24'h0, dbE[i]}, q);
    end
    $display("test debounce finished");
    setup(8'h51, 12'h064, 12'hF9C, 12'h1);
    smp(12'h0C8, 12'h0, 12'h0);
    smp(12'h0, 12'h0, 12'h0);
    rd(IDX_STATUS);
    chkW("latched status", 32'hB0, q);
    rd(IDX_STATUS);
    chkW("latch cleared", 32'h10, q);
    smp(12'hF38, 12'h0, 12'h0);
    smp(12'h0C8, 12'h0, 12'h0);
    rd(IDX_STATUS);
    chkW("latched polarity", 32'hA0, q);
    $display("test latch finished");
    // Count 0 must act at once, like a count of 1
    setup(8'hC9, 12'h032, 12'hFCE, 12'h0);
    wr(IDX_IRQ_MASK, 32'h1);
    step(12'h00A, 12'h0, 12'h0);
    step(12'h046, 12'h0, 12'h0);
    chkB("irq raised", 1'h1, irq);
    rd(IDX_IRQ_ST);
    chkW("irq status rise", 32'h1, q);
    #1 chkB("irq cleared", 1'h0, irq);
    step(12'h046, 12'h0, 12'h0);
    chkB("irq fall masked", 1'h0, irq);
    step(12'h0, 12'h0, 12'h0);
    rd(IDX_IRQ_ST);
    chkW("irq status both", 32'h3, q);
    $display("test relative and interrupt finished");
    summarize();
  end
  // Far beyond the four hundred or so cycles the tests need
  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule
